// ### pedc_mem.sv
// Table memory holding the translation entries, one 32-bit word per address.
// Assumes one port shared by the walker and the register bus, read data registered.
`timescale 1ns/100ps
module pedc_mem #(
	parameter int AW = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);

	// ============================================================
	// Storage
	logic [31:0] mem_reg [0:(1<<AW)-1];

	// Elaboration check of the address width
	if (AW < 4 || AW > 16)
	begin
		$error("pedc_mem: AW out of range");
	end

	// Write port and registered read
	always_ff @(posedge clk)
	begin
		if (en && we)
			mem_reg[addr] <= wdata;
		if (!rst_n)
			rdata <= 32'h0000_0000;
		else if (en)
			rdata <= mem_reg[addr];
	end

endmodule

// ### pedc_pkg.sv
// Shared constants and types of the page entry decode and check block.
// Assumes a 32-bit classic Wishbone register port and 64-bit table entries, or 32-bit entries without address extension.
package pedc_pkg;

	// ============================================================
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ROOT_LO = 8'h04;
	localparam logic [7:0] OFF_ROOT_HI = 8'h08;
	localparam logic [7:0] OFF_VA_LO = 8'h0C;
	localparam logic [7:0] OFF_VA_HI = 8'h10;
	localparam logic [7:0] OFF_CMD = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_PA_LO = 8'h1C;
	localparam logic [7:0] OFF_PA_HI = 8'h20;
	localparam logic [7:0] OFF_MEM_ADDR = 8'h24;
	localparam logic [7:0] OFF_MEM_DATA = 8'h28;

	// ============================================================
	// Entry field positions
	localparam int B_PRESENT = 0;
	localparam int B_WRITABLE = 1;
	localparam int B_USER = 2;
	localparam int B_WT = 3;
	localparam int B_CD = 4;
	localparam int B_ACCESSED = 5;
	localparam int B_DIRTY = 6;
	localparam int B_SIZE = 7;
	localparam int B_GLOBAL = 8;
	localparam int B_ATTR_LARGE = 12;
	localparam int B_NX = 63;

	// ============================================================
	// Control, command and status field positions
	localparam int C_PAE = 0;
	localparam int C_LMA = 1;
	localparam int C_PSE = 2;
	localparam int C_NXE = 3;
	localparam int C_PGE = 4;
	localparam int C_FLUSH = 5;
	localparam int K_GO = 0;
	localparam int K_ACC = 1;
	localparam int S_DONE = 0;
	localparam int S_FAULT = 1;
	localparam int S_NP = 2;
	localparam int S_RSV = 3;
	localparam int S_RIGHTS = 4;
	localparam int S_SIZE = 5;
	localparam int S_GLOBAL = 7;
	localparam int S_ATTR = 8;
	localparam int S_HIT = 11;

	// ============================================================
	// Reset values and widths
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [39:0] ROOT_RST = 40'h00_0000_0000;
	localparam int PA_MAX = 52;

	// ============================================================
	// Walker states and page sizes
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LO = 3'b001,
		ST_HI = 3'b010,
		ST_CHK = 3'b011,
		ST_UPD = 3'b100
	} pedc_state_t;

	typedef enum logic [1:0] {
		SZ_4K = 2'b00,
		SZ_2M = 2'b01,
		SZ_4M = 2'b10,
		SZ_1G = 2'b11
	} pedc_size_t;

endpackage

// ### pedc_soft.sv
// Software side model that formats table entries.
// Assumes the bench sets the fields and takes the entry a cycle later.
`timescale 1ns/100ps
module pedc_soft #(
	parameter int PA_W = 40
) (
	input wire logic [51:0] base,
	input wire logic [12:0] flg,
	input wire logic nx,
	output logic [63:0] ent
);
	logic [51:0] keep;
	assign keep = base & ((52'h1 << PA_W) - 52'h1);
	assign ent = {nx, 11'h000, keep[51:12], 12'h000} | {51'h0, flg};
endmodule

// ### pedc_walk.sv
// Functional notes
// - Next-level tables are 4-Kbyte aligned; low twelve address bits are zero.
// - Base fields are 32-bit without address extension, 52-bit with it.
// - Page base is aligned to page size; offset bits come from address.
// - Entry with presence bit zero raises a page fault.
// - Not-present entries are never cached nor get accessed or dirty set.
// - Other bits of a not-present entry are ignored.
// - Writable bit zero makes mapped pages read-only.
// - User bit zero forbids privilege level three access.
// - Write-through flag selects writeback or writethrough policy.
// - Cache-disable flag marks table or page uncacheable.
// - Accessed flag set on first use, never cleared by hardware.
// - Dirty flag set on first write at leaf, never cleared by hardware.
// - Size flag ends walk; page size from level and mode.
// - Global cached translations survive a root reload when enabled.
// - Software-available bits have no effect.
// - Attribute index is size-or-bit12 flag over cache-disable and write-through.
// - No-execute flag at bit 63 forbids fetches, except legacy pointer entries.
// - No-execute flag set while feature disabled is a reserved fault.
// - Long mode or extended legacy mode faults on nonzero reserved bits; the code checks legacy mode only with both PAE and PSE set.
// - Cached entry always has its accessed flag set at the same time.
// - Dirty flag never set speculatively; clean dirty means never written.
// - Long-mode index fields are 47:39, 38:30, 29:21, 20:12, 512 entries each.
//
// Page-table walker with one-entry translation cache behind classic Wishbone.
// Assumes software loads tables into the local table memory before walking.
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module pedc_walk #(
	parameter int AW = 10,
	parameter int PA_W = 40
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic PAGE_FAULT,
	output logic WALK_BUSY
);

	// ============================================================
	// State
	typedef struct packed {
		pedc_pkg::pedc_state_t st;
		logic busy;
		logic [4:0] ctl;
		logic [39:0] root;
		logic [47:0] va;
		logic [2:0] acc;
		logic [1:0] lvl;
		logic [63:0] ent;
		logic [51:0] eaddr;
		logic wok;
		logic uok;
		logic nx;
		logic [11:0] stat;
		logic [51:0] pa;
		logic c_valid;
		logic c_glob;
		logic c_w;
		logic c_u;
		logic c_nx;
		logic c_dirty;
		logic [35:0] c_tag;
		logic [51:0] c_pa;
		logic [1:0] c_size;
		logic [2:0] c_attr;
		logic [AW-1:0] maddr;
		logic fresh;
		logic ack;
		logic fault;
		logic [31:0] dat;
	} pedc_main_t;

	localparam pedc_main_t MAIN_RST = '{st: pedc_pkg::ST_IDLE, ctl: pedc_pkg::CTRL_RST,
		root: pedc_pkg::ROOT_RST, default: '0};

	pedc_main_t s;
	pedc_main_t n;
	logic m_we;
	logic [AW-1:0] m_addr;
	logic [31:0] m_wdata;
	logic [31:0] rdata;

	// Elaboration check of the parameters
	if (PA_W < 32 || PA_W > pedc_pkg::PA_MAX || AW < 4 || AW > 16)
	begin
		$error("pedc_walk: parameter out of range");
	end

	// ============================================================
	// Helpers
	// Offset bits inside a page of the given size
	function automatic logic [51:0] off_mask(input logic [1:0] sz);
		unique case (pedc_pkg::pedc_size_t'(sz))
			pedc_pkg::SZ_4K: off_mask = 52'h0_0000_0000_0FFF;
			pedc_pkg::SZ_2M: off_mask = 52'h0_0000_001F_FFFF;
			pedc_pkg::SZ_4M: off_mask = 52'h0_0000_003F_FFFF;
			pedc_pkg::SZ_1G: off_mask = 52'h0_0000_3FFF_FFFF;
		endcase
	endfunction

	// Entry address of the given level below a table base
	function automatic logic [51:0] entry_addr(input logic [39:0] base, input logic [47:0] va,
		input logic [1:0] lvl, input logic pae);
		logic [8:0] idx;
		idx = 9'h000;
		unique case (lvl)
			2'd3: idx = va[47:39];
			2'd2: idx = va[38:30];
			2'd1: idx = va[29:21];
			2'd0: idx = va[20:12];
		endcase
		if (pae)
			entry_addr = {base, idx, 3'b000};
		else if (lvl == 2'd1)
			entry_addr = {20'h0_0000, base[19:0], va[31:22], 2'b00};
		else
			entry_addr = {20'h0_0000, base[19:0], va[21:12], 2'b00};
	endfunction

	// ============================================================
	// Table memory
	pedc_mem #(.AW(AW)) u_mem (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.en(CLK_EN),
		.we(m_we),
		.addr(m_addr),
		.wdata(m_wdata),
		.rdata(rdata)
	);

	// ============================================================
	// Next-state logic
	always_comb
	begin
		logic req;
		logic idle;
		logic is_mem;
		logic [7:0] adr;
		logic [31:0] rd;
		logic [31:0] bm;
		logic [31:0] wv;
		logic pae;
		logic lm;
		logic [63:0] e;
		logic has_nx;
		logic nxb;
		logic leaf;
		logic [1:0] sz;
		logic [51:0] base;
		logic rsv;
		logic wok_n;
		logic uok_n;
		logic nx_n;
		logic bad;
		logic need_a;
		logic need_d;
		logic adv;
		logic hit;
		logic [1:0] lvl0;
		logic [51:0] cm;
		n = s;
		m_we = 1'b0;
		m_wdata = 32'h0000_0000;
		adv = 1'b0;
		lvl0 = 2'd0;
		cm = off_mask(s.c_size);
		hit = 1'b0;
		req = WB_CYC_I & WB_STB_I;
		idle = (s.st == pedc_pkg::ST_IDLE);
		adr = {WB_ADR_I[7:2], 2'b00};
		is_mem = (adr == pedc_pkg::OFF_MEM_DATA);
		pae = s.ctl[pedc_pkg::C_PAE];
		lm = s.ctl[pedc_pkg::C_LMA];
		m_addr = idle ? s.maddr : s.eaddr[AW+1:2];
		bm = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

		// Register readback
		unique case (adr)
			pedc_pkg::OFF_CTRL: rd = {27'h0, s.ctl};
			pedc_pkg::OFF_ROOT_LO: rd = {s.root[19:0], 12'h000};
			pedc_pkg::OFF_ROOT_HI: rd = {12'h000, s.root[39:20]};
			pedc_pkg::OFF_VA_LO: rd = s.va[31:0];
			pedc_pkg::OFF_VA_HI: rd = {16'h0000, s.va[47:32]};
			pedc_pkg::OFF_CMD: rd = {28'h0, s.acc, s.busy};
			pedc_pkg::OFF_STATUS: rd = {20'h0_0000, s.stat};
			pedc_pkg::OFF_PA_LO: rd = s.pa[31:0];
			pedc_pkg::OFF_PA_HI: rd = {12'h000, s.pa[51:32]};
			pedc_pkg::OFF_MEM_ADDR: rd = 32'(s.maddr);
			pedc_pkg::OFF_MEM_DATA: rd = rdata;
			default: rd = 32'h0000_0000;
		endcase
		wv = (rd & ~bm) | (WB_DAT_I & bm);

		// Bus answer; writes stall while walking, memory data waits for fresh read
		n.ack = req & ~s.ack & (~WB_WE_I | idle) & (~is_mem | (idle & s.fresh));
		if (n.ack)
			n.dat = rd;

		// Entry classification
		e = (s.st == pedc_pkg::ST_CHK) ? {pae ? rdata : 32'h0000_0000, s.ent[31:0]} : s.ent;
		has_nx = pae & ~(s.lvl == 2'd2 & ~lm);
		nxb = has_nx & e[pedc_pkg::B_NX];
		leaf = (s.lvl == 2'd0) | (e[pedc_pkg::B_SIZE] & ((s.lvl == 2'd1) | (s.lvl == 2'd2 & lm)));
		sz = (s.lvl == 2'd0) ? pedc_pkg::SZ_4K : (s.lvl == 2'd2) ? pedc_pkg::SZ_1G :
			pae ? pedc_pkg::SZ_2M : pedc_pkg::SZ_4M;
		base = pae ? {e[51:12], 12'h000} : {20'h0_0000, e[31:12], 12'h000};
		// bits above implemented width must be clear
		rsv = (lm | (pae & s.ctl[pedc_pkg::C_PSE])) & ((pae & (|(e[51:0] >> PA_W))) |
			(leaf & (|(e[51:0] & off_mask(sz) & ~52'h0_0000_0000_1FFF))));
		rsv = rsv | (nxb & ~s.ctl[pedc_pkg::C_NXE]);
		wok_n = s.wok & e[pedc_pkg::B_WRITABLE];
		uok_n = s.uok & e[pedc_pkg::B_USER];
		nx_n = s.nx | nxb;
		bad = leaf & ((s.acc[0] & ~wok_n) | (s.acc[1] & ~uok_n) | (s.acc[2] & nx_n));
		need_a = ~e[pedc_pkg::B_ACCESSED];
		// dirty set on first write at leaf
		need_d = leaf & s.acc[0] & ~e[pedc_pkg::B_DIRTY];

		// Walker sequence
		unique case (s.st)
			pedc_pkg::ST_IDLE:
			begin
			end
			pedc_pkg::ST_LO:
				n.st = pedc_pkg::ST_HI;
			pedc_pkg::ST_HI:
			begin
				m_addr = s.eaddr[AW+1:2] + AW'(1);
				n.ent[31:0] = rdata;
				n.st = pedc_pkg::ST_CHK;
			end
			pedc_pkg::ST_CHK:
			begin
				if (!e[pedc_pkg::B_PRESENT])
				begin
					// no cache fill, no flag update
					n.stat = '0;
					n.stat[pedc_pkg::S_NP] = 1'b1;
				end
				else if (rsv)
				begin
					n.stat = '0;
					n.stat[pedc_pkg::S_RSV] = 1'b1;
				end
				else if (bad)
				begin
					n.stat = '0;
					n.stat[pedc_pkg::S_RIGHTS] = 1'b1;
				end
				n.ent = {e[63:32], e[31:7], e[6] | need_d, 1'b1, e[4:0]};
				n.wok = wok_n;
				n.uok = uok_n;
				n.nx = nx_n;
				if (!e[pedc_pkg::B_PRESENT] || rsv || bad)
				begin
					n.stat[pedc_pkg::S_DONE] = 1'b1;
					n.stat[pedc_pkg::S_FAULT] = 1'b1;
					n.fault = 1'b1;
					n.busy = 1'b0;
					n.st = pedc_pkg::ST_IDLE;
				end
				else if (need_a | need_d)
					n.st = pedc_pkg::ST_UPD;
				else
					adv = 1'b1;
			end
			pedc_pkg::ST_UPD:
			begin
				// atomic write-back, bus writes and memory data held off while busy
				m_we = 1'b1;
				m_wdata = s.ent[31:0];
				adv = 1'b1;
			end
			default:
			begin
				n.st = pedc_pkg::ST_IDLE;
				n.busy = 1'b0;
			end
		endcase

		// Step down a level or finish the walk
		if (adv)
		begin
			if (leaf)
			begin
				n.pa = (base & ~off_mask(sz)) | ({4'h0, s.va} & off_mask(sz));
				n.stat = '0;
				n.stat[pedc_pkg::S_DONE] = 1'b1;
				n.stat[pedc_pkg::S_SIZE +: 2] = sz;
				n.stat[pedc_pkg::S_GLOBAL] = e[pedc_pkg::B_GLOBAL];
				n.stat[pedc_pkg::S_ATTR +: 3] = {(s.lvl == 2'd0) ? e[pedc_pkg::B_SIZE] :
					e[pedc_pkg::B_ATTR_LARGE], e[pedc_pkg::B_CD], e[pedc_pkg::B_WT]};
				// cached only with accessed set, or written back on the same edge
				n.c_valid = 1'b1;
				n.c_glob = e[pedc_pkg::B_GLOBAL];
				n.c_tag = s.va[47:12];
				n.c_pa = base & ~off_mask(sz);
				n.c_size = sz;
				n.c_w = wok_n;
				n.c_u = uok_n;
				n.c_nx = nx_n;
				n.c_dirty = e[pedc_pkg::B_DIRTY] | s.acc[0];
				n.c_attr = n.stat[pedc_pkg::S_ATTR +: 3];
				n.busy = 1'b0;
				n.st = pedc_pkg::ST_IDLE;
			end
			else
			begin
				n.eaddr = entry_addr(base[51:12], s.va, s.lvl - 2'd1, pae);
				n.lvl = s.lvl - 2'd1;
				n.st = pedc_pkg::ST_LO;
			end
		end

		// Register writes take effect on the acknowledged edge
		if (s.ack && req && WB_WE_I)
		begin
			unique case (adr)
				pedc_pkg::OFF_CTRL:
				begin
					if (wv[pedc_pkg::C_FLUSH] || wv[4:0] != s.ctl)
						n.c_valid = 1'b0;
					n.ctl = wv[4:0];
				end
				pedc_pkg::OFF_ROOT_LO, pedc_pkg::OFF_ROOT_HI:
				begin
					if (adr == pedc_pkg::OFF_ROOT_LO)
						n.root[19:0] = wv[31:12];
					else
						n.root[39:20] = wv[19:0];
					n.c_valid = s.c_valid & s.c_glob & s.ctl[pedc_pkg::C_PGE];
				end
				pedc_pkg::OFF_VA_LO: n.va[31:0] = wv;
				pedc_pkg::OFF_VA_HI: n.va[47:32] = wv[15:0];
				pedc_pkg::OFF_MEM_ADDR: n.maddr = wv[AW-1:0];
				pedc_pkg::OFF_MEM_DATA:
				begin
					m_we = 1'b1;
					m_wdata = wv;
					n.maddr = s.maddr + AW'(1);
				end
				pedc_pkg::OFF_CMD:
				begin
					n.acc = wv[pedc_pkg::K_ACC +: 3];
					if (wv[pedc_pkg::K_GO])
					begin
						n.fault = 1'b0;
						if (!lm)
							n.va[47:32] = 16'h0000;
						// write hits need dirty already set
						hit = s.c_valid & ((((n.va[47:12] ^ s.c_tag) &
							~cm[47:12]) == 36'h0) &
							(~n.acc[0] | (s.c_w & s.c_dirty)) & (~n.acc[1] | s.c_u) &
							(~n.acc[2] | ~s.c_nx));
						lvl0 = lm ? 2'd3 : pae ? 2'd2 : 2'd1;
						n.stat = '0;
						if (hit)
						begin
							n.pa = s.c_pa | ({4'h0, n.va} & off_mask(s.c_size));
							n.stat[pedc_pkg::S_DONE] = 1'b1;
							n.stat[pedc_pkg::S_HIT] = 1'b1;
							n.stat[pedc_pkg::S_SIZE +: 2] = s.c_size;
							n.stat[pedc_pkg::S_GLOBAL] = s.c_glob;
							n.stat[pedc_pkg::S_ATTR +: 3] = s.c_attr;
						end
						else
						begin
							n.eaddr = entry_addr(s.root, n.va, lvl0, pae);
							n.lvl = lvl0;
							n.wok = 1'b1;
							n.uok = 1'b1;
							n.nx = 1'b0;
							n.busy = 1'b1;
							n.st = pedc_pkg::ST_LO;
						end
					end
				end
				default:
				begin
				end
			endcase
		end
		else if (s.ack && req && is_mem)
			n.maddr = s.maddr + AW'(1);

		// Memory read data valid for the bus address
		n.fresh = idle & (n.st == pedc_pkg::ST_IDLE) & ~m_we & (n.maddr == s.maddr);
	end

	// ============================================================
	// State register
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			s <= MAIN_RST;
		else if (CLK_EN)
			s <= n;
	end

	// Outputs straight from state
	assign WB_DAT_O = s.dat;
	assign WB_ACK_O = s.ack;
	assign PAGE_FAULT = s.fault;
	assign WALK_BUSY = s.busy;

endmodule

// ### pedc_walk_sva.sv
// Port checker for the page walker.
// Assumes it is bound to pedc_walk and sees only its ports.
`timescale 1ns/100ps
module pedc_walk_sva (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic WB_ACK_O,
	input wire logic PAGE_FAULT,
	input wire logic WALK_BUSY
);
	// ============================================================
	// Clocking and helpers
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	logic go_w;
	// Acked write of the start bit
	assign go_w = WB_ACK_O && WB_WE_I && WB_ADR_I[7:2] == 6'h05 && WB_DAT_I[0];

	// ============================================================
	// Properties
	property p_ack_pulse;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_req;
		WB_ACK_O |-> WB_CYC_I && WB_STB_I;
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");
	property p_rst;
		disable iff (1'b0) !RST_N && CLK_EN |=> !WB_ACK_O && !WALK_BUSY && !PAGE_FAULT;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_busy_cause;
		$rose(WALK_BUSY) |-> $past(go_w) || $past(go_w, 2);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("walk began without start");
	property p_busy_end;
		$rose(WALK_BUSY) |-> ##[1:24] !WALK_BUSY;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("walk too long");
	property p_wr_idle;
		WB_ACK_O && WB_WE_I |-> !WALK_BUSY;
	endproperty
	a_wr_idle: assert property (p_wr_idle) else $error("write taken during walk");
	property p_fault_clr;
		$fell(PAGE_FAULT) |-> go_w || $past(go_w) || $past(go_w, 2);
	endproperty
	a_fault_clr: assert property (p_fault_clr) else $error("fault dropped without start");
	property p_fault_rise;
		$rose(PAGE_FAULT) |-> !WALK_BUSY;
	endproperty
	a_fault_rise: assert property (p_fault_rise) else $error("fault raised mid walk");
	c_walk: cover property ($rose(WALK_BUSY));
	c_fault: cover property ($rose(PAGE_FAULT));
	c_hit: cover property (go_w ##1 !WALK_BUSY ##1 !WALK_BUSY);
endmodule

bind pedc_walk pedc_walk_sva chk_u (
	.REF_CLK(REF_CLK),
	.RST_N(RST_N),
	.CLK_EN(CLK_EN),
	.WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I),
	.WB_DAT_I(WB_DAT_I),
	.WB_ACK_O(WB_ACK_O),
	.PAGE_FAULT(PAGE_FAULT),
	.WALK_BUSY(WALK_BUSY)
);

// ### testbench.sv
// Self-checking bench for the page walker with a reference walk model.
// Assumes the walker, the entry formatter and the checker are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", n, e, s); end end
module testbench;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, fault, busy, s_nx;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, dout, rd;
	logic [51:0] s_base;
	logic [12:0] s_flg;
	logic [63:0] s_ent;
	logic [31:0] img [int];
	int q[$];
	int bad_count = 0, comparisons = 0;
	int lvl_t [10] = '{0, 1, 2, 0, 0, 0, 0, 0, 1, 0};
	int flg_t [10] = '{'hE07, 'h109F, 'h87, 'h1FFE, 5, 3, 7, 7, 'h87, 'h18F};
	int acc_t [10] = '{2, 0, 4, 2, 2, 4, 8, 0, 0, 0};
	int nx_t [10] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0};
	int nxe_t [10] = '{1, 1, 1, 1, 1, 1, 1, 0, 1, 1};

	// ============================================================
	// Design, formatter and clock
	pedc_walk #(.AW(12), .PA_W(40)) dut_u (.REF_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
		.WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .PAGE_FAULT(fault), .WALK_BUSY(busy));
	pedc_soft #(.PA_W(40)) soft_u (.base(s_base), .flg(s_flg), .nx(s_nx), .ent(s_ent));
	// Free running clock
	initial
	begin
		forever #25 clk = ~clk;
	end

	// ============================================================
	// Tasks and reference model
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One classic bus cycle, held until ack
	task automatic wb(input bit w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && n < 60)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 60)
		begin
			bad_count++;
			tally_and_finish();
		end
		rd = dout;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	// Store one entry in table memory and the mirror
	task automatic put(input int wa, input logic [51:0] b, input logic [12:0] f, input bit x);
		s_base = b;
		s_flg = f;
		s_nx = x;
		@(posedge clk);
		img[wa] = s_ent[31:0];
		img[wa + 1] = s_ent[63:32];
		wb(1, pedc_pkg::OFF_MEM_ADDR, 32'(wa));
		wb(1, pedc_pkg::OFF_MEM_DATA, s_ent[31:0]);
		wb(1, pedc_pkg::OFF_MEM_DATA, s_ent[63:32]);
	endtask
	// Start a walk and poll until it ends
	task automatic walk(input logic [47:0] va, input logic [3:0] acc, output logic [31:0] st);
		int n;
		n = 0;
		st = 0;
		wb(1, pedc_pkg::OFF_VA_LO, va[31:0]);
		wb(1, pedc_pkg::OFF_VA_HI, {16'h0000, va[47:32]});
		wb(1, pedc_pkg::OFF_CMD, {28'h0, acc | 4'h1});
		while (st[1:0] == 2'b00 && n < 40)
		begin
			wb(0, pedc_pkg::OFF_STATUS, 0);
			st = rd;
			n++;
		end
		if (n >= 40)
		begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	// Long-mode walk over the mirror, updating flags as hardware should
	function automatic void mdl(input logic [47:0] va, input logic [3:0] acc, input bit nxe,
		output logic [3:0] flt, output logic [51:0] pa, output logic [4:0] sa);
		logic [63:0] e;
		logic [51:0] b, m;
		int wa, lv;
		bit w, u, x, leaf;
		b = 52'h0;
		w = 1;
		u = 1;
		x = 1;
		flt = 4'h0;
		q.delete();
		for (lv = 3; lv >= 0; lv--)
		begin
			wa = int'(b[13:2]) + 2 * int'(va[12 + 9 * lv +: 9]);
			e = {img[wa + 1], img[wa]};
			leaf = lv == 0 || (lv < 3 && e[7]);
			q.push_back(wa);
			if (!e[0])
				flt = 4'b0011;
			else if ((e[63] && !nxe) || (leaf && lv > 0 &&
				(e[51:0] & ((52'h1 << (12 + 9 * lv)) - 52'h1) & ~52'h1FFF) != 52'h0))
				flt = 4'b0101;
			else
			begin
				w &= e[1];
				u &= e[2];
				x &= !e[63];
				if (leaf && ((acc[1] && !w) || (acc[2] && !u) || (acc[3] && !x)))
					flt = 4'b1001;
				else
				begin
					img[wa][5] = 1'b1;
					img[wa][6] = img[wa][6] | (leaf && acc[1]);
				end
			end
			m = (52'h1 << (12 + 9 * lv)) - 52'h1;
			pa = (e[51:0] & ~m) | ({4'h0, va} & m);
			sa = {2'(lv == 2 ? 3 : lv), lv == 0 ? e[7] : e[12], e[4], e[3]};
			if (flt != 0 || leaf)
				return;
			b = {e[51:12], 12'h000};
		end
	endfunction

	// ============================================================
	// Main sequence
	initial
	begin
		logic [47:0] va;
		logic [51:0] pb, pa;
		logic [31:0] st;
		logic [3:0] flt;
		logic [4:0] sa;
		int i, l, lv;
		i = $urandom(71);
		repeat (2) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		wb(0, 8'hFC, 0);
		`CHK("unmapped read", 32'h0, rd)
		for (i = 0; i < 10; i++)
		begin
			lv = lvl_t[i];
			va = {1'b0, 15'($urandom()), 32'($urandom())};
			pb = {12'h0, 28'($urandom()), 12'h0} & ~((52'h1 << (12 + 9 * lv)) - 52'h1);
			pb = pb | (i == 8 ? 52'h2000 : 52'h0);
			wb(1, pedc_pkg::OFF_CTRL, 32'h33 | (32'(nxe_t[i]) << 3));
			for (l = 3; l >= lv; l--)
				put(1024 * (3 - l) + 2 * int'(va[12 + 9 * l +: 9]), l == lv ? pb : 52'(4096 * (4 - l)),
					l == lv ? 13'(flg_t[i]) : 13'h0007, l == lv && nx_t[i] != 0);
			mdl(va, 4'(acc_t[i]), nxe_t[i] != 0, flt, pa, sa);
			walk(va, 4'(acc_t[i]), st);
			`CHK("fault bits", flt, st[4:1])
			`CHK("fault pin", flt[0], fault)
			`CHK("busy after walk", 1'b0, busy)
			if (flt == 0)
			begin
				wb(0, pedc_pkg::OFF_PA_LO, 0);
				`CHK("page address low", pa[31:0], rd)
				wb(0, pedc_pkg::OFF_PA_HI, 0);
				`CHK("page address high", {12'h0, pa[51:32]}, rd)
				`CHK("size and index", sa, {st[6:5], st[10:8]})
				`CHK("global flag", flg_t[i][8], st[7])
			end
			foreach (q[k])
			begin
				wb(1, pedc_pkg::OFF_MEM_ADDR, 32'(q[k]));
				wb(0, pedc_pkg::OFF_MEM_DATA, 0);
				`CHK("entry low word", img[q[k]], rd)
			end
			if (flt == 0)
			begin
				wb(1, pedc_pkg::OFF_ROOT_LO, 0);
				walk(va, 4'h0, st);
				`CHK("hit after root reload", flg_t[i][8], st[11])
			end
			$display("test %0d finished", i);
		end
		// Legacy 32-bit mode, one 4-Mbyte page at the directory level
		va = {16'h0000, 32'($urandom())};
		pb = {20'h0_0000, 10'($urandom()), 22'h00_0000};
		wb(1, pedc_pkg::OFF_CTRL, 32'h0000_0020);
		wb(1, pedc_pkg::OFF_MEM_ADDR, 32'(va[31:22]));
		wb(1, pedc_pkg::OFF_MEM_DATA, pb[31:0] | 32'h0000_0097);
		walk(va, 4'h0, st);
		`CHK("legacy status", (32'h1 << pedc_pkg::S_DONE) | (32'h2 << pedc_pkg::S_SIZE) |
			(32'h2 << pedc_pkg::S_ATTR), st)
		wb(0, pedc_pkg::OFF_PA_LO, 0);
		`CHK("legacy page address", {pb[31:22], va[21:0]}, rd)
		wb(1, pedc_pkg::OFF_MEM_ADDR, 32'(va[31:22]));
		wb(0, pedc_pkg::OFF_MEM_DATA, 0);
		`CHK("legacy entry", pb[31:0] | 32'h0000_00B7, rd)
		$display("test legacy finished");
		tally_and_finish();
	end
endmodule
